//--- src/slc_consts.vh
// constants for the sysref / lmfc alignment control block
`ifndef SLC_CONSTS_VH
`define SLC_CONSTS_VH

// byte address of the sync and sysref control register
`define SLC_ADDR_SYNC_SYSREF_CTRL 12'h054

// field positions inside the control register
`define SLC_BIT_CGS_BYPASS        20
`define SLC_OFFSET_HI             19
`define SLC_OFFSET_LO             12
`define SLC_SPARE_HI              6
`define SLC_SPARE_LO              3
`define SLC_BIT_SYSREF_SINGLE     2

// reset value: single detect armed, everything else clear
`define SLC_CTRL_RESET            32'h00000004
// mask of bits that hold storage (others read as zero)
`define SLC_CTRL_RW_MASK          32'h001FF07C

// subclass code in which the cgs bypass acts
`define SLC_SUBCLASS_1            2'h1

// axi response codes
`define SLC_RESP_OKAY             2'h0
`define SLC_RESP_SLVERR           2'h2

// lmfc divide: multiframe length in link clocks is f*k/4
`define SLC_LMFC_DIV_SHIFT        2

`endif

//--- src/slc_sysref_sync.v
// two-stage synchroniser and rising edge detector for the sysref pin
`timescale 1ns/1ps
module slc_sysref_sync (
    input  wire clk_i,        // link clock
    input  wire rst_i,        // synchronous reset, active high
    input  wire sysref_i,     // asynchronous sysref pin
    output reg  sysref_rise_o // one-cycle pulse per sampled rising edge
);

    reg meta_r;   // first stage, read only by sync_r
    reg sync_r;   // second stage, safe to use
    reg last_r;   // previous synchronised level

    // synchronise the pin, then compare against the last level
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_r        <= 1'b0;
            sync_r        <= 1'b0;
            last_r        <= 1'b0;
            sysref_rise_o <= 1'b0;
        end else begin
            meta_r        <= sysref_i;
            sync_r        <= meta_r;
            last_r        <= sync_r;
            sysref_rise_o <= sync_r & ~last_r;
        end
    end

endmodule // slc_sysref_sync

//--- src/slc_lmfc_counter.v
// local multiframe counter with preset load and boundary tick
`timescale 1ns/1ps
`include "slc_consts.vh"
module slc_lmfc_counter #(
    parameter CNT_W = 11      // counter width, covers f*k/4 up to 2048
) (
    input  wire             clk_i,    // link clock
    input  wire             rst_i,    // synchronous reset, active high
    input  wire [CNT_W-1:0] last_i,   // highest count of one multiframe
    input  wire             load_i,   // load preset this cycle
    input  wire [7:0]       preset_i, // programmed preset
    output reg  [CNT_W-1:0] cnt_o,    // running count
    output reg              tick_o    // one pulse per wrap
);

    wire [CNT_W-1:0] preset_ext; // preset at counter width
    wire [CNT_W-1:0] preset_use; // preset after range check

    assign preset_ext = {{(CNT_W-8){1'b0}}, preset_i};
    // an out-of-range preset falls back to zero
    assign preset_use = (preset_ext > last_i) ? {CNT_W{1'b0}} : preset_ext;

    // count 0..last, wrap to zero, tick on each wrap
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_o  <= {CNT_W{1'b0}};
            tick_o <= 1'b0;
        end else if (load_i) begin
            cnt_o  <= preset_use;
            tick_o <= 1'b0;
        end else if (cnt_o >= last_i) begin
            cnt_o  <= {CNT_W{1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt_o  <= cnt_o + {{(CNT_W-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end

endmodule // slc_lmfc_counter

//--- src/slc_align_ctrl.v
// sysref to lmfc alignment control with an axi4-lite register port
//
// Notes on behaviour
// - bypass acts only in subclass 1
// - without bypass, hold cgs until sysref sampled
// - leave cgs only on an lmfc tick
// - bypass set allows exit without sysref
// - preset field holds count minus one
// - sysref edge loads counter with preset
// - counter runs 0 to f*k/4 minus 1
// - out-of-range preset replaced by zero
// - armed realign loads counter with preset, then self-clears
// - disarmed realign ignores sysref edges
// - no cgs exit before first sysref unless bypassed
// - spare bits 6..3 plain storage, reset zero
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "slc_consts.vh"
module slc_align_ctrl #(
    parameter CNT_W = 11                    // lmfc counter width
) (
    input  wire             CLK_I,          // link clock, 20 MHz
    input  wire             RST_I,          // synchronous reset, active high
    // axi4-lite write address channel
    input  wire [11:0]      S_AXI_AWADDR_I,
    input  wire             S_AXI_AWVALID_I,
    output reg              S_AXI_AWREADY_O,
    // axi4-lite write data channel
    input  wire [31:0]      S_AXI_WDATA_I,
    input  wire [3:0]       S_AXI_WSTRB_I,
    input  wire             S_AXI_WVALID_I,
    output reg              S_AXI_WREADY_O,
    // axi4-lite write response channel
    output reg  [1:0]       S_AXI_BRESP_O,
    output reg              S_AXI_BVALID_O,
    input  wire             S_AXI_BREADY_I,
    // axi4-lite read address channel
    input  wire [11:0]      S_AXI_ARADDR_I,
    input  wire             S_AXI_ARVALID_I,
    output reg              S_AXI_ARREADY_O,
    // axi4-lite read data channel
    output reg  [31:0]      S_AXI_RDATA_O,
    output reg  [1:0]       S_AXI_RRESP_O,
    output reg              S_AXI_RVALID_O,
    input  wire             S_AXI_RREADY_I,
    // link configuration, same clock domain
    input  wire [1:0]       SUBCLASS_I,     // link subclass code
    input  wire [7:0]       CFG_F_I,        // octets per frame
    input  wire [5:0]       CFG_K_I,        // frames per multiframe
    // link layer handshake, same clock domain
    input  wire             LINK_RESET_I,   // return to cgs, forget sysref
    input  wire             CGS_DONE_I,     // code group sync achieved
    // sysref pin, asynchronous
    input  wire             SYSREF_I,
    // status toward the link layer
    output wire [CNT_W-1:0] LMFC_CNT_O,     // lmfc count
    output wire             LMFC_TICK_O,    // multiframe boundary pulse
    output reg              IN_CGS_O,       // link layer held in cgs
    output reg              ILAS_START_O,   // pulse: cgs left for ilas
    output reg              SYSREF_SEEN_O   // an armed sysref edge was sampled and realigned the counter
);

    // link layer states
    localparam [0:0] ST_CGS  = 1'b0;        // code group sync
    localparam [0:0] ST_ILAS = 1'b1;        // alignment sequence and on

    // ------------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------------
    reg  [31:0] ctrl_r;                     // control register storage
    reg  [31:0] ctrl_nxt;                   // its next value

    wire        cgs_bypass;                 // bypass of sysref wait
    wire [7:0]  lmfc_preset;                // multiframe counter preset
    wire        single_det;                 // one-shot realign armed

    assign cgs_bypass  = ctrl_r[`SLC_BIT_CGS_BYPASS];
    // the field already holds the count minus one, used as is
    assign lmfc_preset = ctrl_r[`SLC_OFFSET_HI:`SLC_OFFSET_LO];
    assign single_det  = ctrl_r[`SLC_BIT_SYSREF_SINGLE];

    // ------------------------------------------------------------------
    // axi write path state
    // ------------------------------------------------------------------
    reg         aw_held_r;                  // address accepted, waiting
    reg  [11:0] aw_addr_r;                  // accepted write address
    reg         w_held_r;                   // data accepted, waiting
    reg  [31:0] w_data_r;                   // accepted write data
    reg  [3:0]  w_strb_r;                   // accepted byte enables

    wire        aw_fire;                    // address handshake now
    wire        w_fire;                     // data handshake now
    wire        wr_go;                      // both halves present
    wire [11:0] wr_addr;                    // address used for the write
    wire [31:0] wr_data;                    // data used for the write
    wire [3:0]  wr_strb;                    // enables used for the write
    wire        wr_hit;                     // write hits the register
    wire [31:0] wr_mask;                    // byte lanes written

    assign aw_fire = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
    assign w_fire  = S_AXI_WVALID_I & S_AXI_WREADY_O;
    assign wr_go   = (aw_fire | aw_held_r) & (w_fire | w_held_r);
    assign wr_addr = aw_held_r ? aw_addr_r : S_AXI_AWADDR_I;
    assign wr_data = w_held_r ? w_data_r : S_AXI_WDATA_I;
    assign wr_strb = w_held_r ? w_strb_r : S_AXI_WSTRB_I;
    assign wr_hit  = wr_go & (wr_addr == `SLC_ADDR_SYNC_SYSREF_CTRL);
    assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                      {8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // ------------------------------------------------------------------
    // sysref edge and lmfc counter
    // ------------------------------------------------------------------
    wire        sysref_rise;                // synchronised rising edge
    wire        realign;                    // edge that realigns now
    wire [CNT_W-1:0] lmfc_last;             // last count of a multiframe

    // pin passes two flip-flops before the edge detector
    slc_sysref_sync u_sync (
        .clk_i         (CLK_I),
        .rst_i         (RST_I),
        .sysref_i      (SYSREF_I),
        .sysref_rise_o (sysref_rise)
    );

    // only an armed one-shot lets an edge touch the counter
    assign realign = sysref_rise & single_det;

    // multiframe length in link clocks, less one
    function [CNT_W-1:0] lmfc_last_f;
        input [7:0] f;
        input [5:0] k;
        reg   [13:0] prod;
        begin
            prod = f * k;
            prod = prod >> `SLC_LMFC_DIV_SHIFT;
            if (prod == 14'h0000) begin
                lmfc_last_f = {CNT_W{1'b0}};
            end else begin
                lmfc_last_f = prod[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    assign lmfc_last = lmfc_last_f(CFG_F_I, CFG_K_I);

    // counter reloads with the preset on each realigning edge
    slc_lmfc_counter #(
        .CNT_W (CNT_W)
    ) u_lmfc (
        .clk_i    (CLK_I),
        .rst_i    (RST_I),
        .last_i   (lmfc_last),
        .load_i   (realign),
        .preset_i (lmfc_preset),
        .cnt_o    (LMFC_CNT_O),
        .tick_o   (LMFC_TICK_O)
    );

    // ------------------------------------------------------------------
    // control register update
    // ------------------------------------------------------------------
    // software write merges byte lanes; hardware clears the one-shot
    always @* begin
        ctrl_nxt = ctrl_r;
        if (realign) begin
            // armed realign disarms itself once sysref was sampled
            ctrl_nxt[`SLC_BIT_SYSREF_SINGLE] = 1'b0;
        end
        if (wr_hit) begin
            // spare bits are plain storage with no effect
            ctrl_nxt = (ctrl_nxt & ~(wr_mask & `SLC_CTRL_RW_MASK)) |
                       (wr_data & wr_mask & `SLC_CTRL_RW_MASK);
        end
    end

    // register storage, reset to its documented value
    always @(posedge CLK_I) begin
        if (RST_I) begin
            ctrl_r <= `SLC_CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // axi write channels
    // ------------------------------------------------------------------
    // each half is held until the other arrives, then answered once
    always @(posedge CLK_I) begin
        if (RST_I) begin
            aw_held_r       <= 1'b0;
            aw_addr_r       <= 12'h000;
            w_held_r        <= 1'b0;
            w_data_r        <= 32'h00000000;
            w_strb_r        <= 4'h0;
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O  <= 1'b1;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= `SLC_RESP_OKAY;
        end else begin
            // address taken: stop taking more until the response
            if (aw_fire) begin
                aw_addr_r       <= S_AXI_AWADDR_I;
                S_AXI_AWREADY_O <= 1'b0;
            end
            // data taken: same treatment
            if (w_fire) begin
                w_data_r       <= S_AXI_WDATA_I;
                w_strb_r       <= S_AXI_WSTRB_I;
                S_AXI_WREADY_O <= 1'b0;
            end
            if (wr_go) begin
                // both halves in: raise the response
                aw_held_r      <= 1'b0;
                w_held_r       <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O  <= wr_hit ? `SLC_RESP_OKAY : `SLC_RESP_SLVERR;
            end else begin
                // remember which half is waiting
                if (aw_fire) begin
                    aw_held_r <= 1'b1;
                end
                if (w_fire) begin
                    w_held_r <= 1'b1;
                end
            end
            // response taken: open both channels again
            if (S_AXI_BVALID_O & S_AXI_BREADY_I) begin
                S_AXI_BVALID_O  <= 1'b0;
                S_AXI_AWREADY_O <= 1'b1;
                S_AXI_WREADY_O  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // axi read channels
    // ------------------------------------------------------------------
    // one read at a time; data registered with the address handshake
    always @(posedge CLK_I) begin
        if (RST_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h00000000;
            S_AXI_RRESP_O   <= `SLC_RESP_OKAY;
        end else if (S_AXI_ARVALID_I & S_AXI_ARREADY_O) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b1;
            if (S_AXI_ARADDR_I == `SLC_ADDR_SYNC_SYSREF_CTRL) begin
                // reserved bits read as zero
                S_AXI_RDATA_O <= ctrl_r & `SLC_CTRL_RW_MASK;
                S_AXI_RRESP_O <= `SLC_RESP_OKAY;
            end else begin
                // unmapped address: zero data, slave error
                S_AXI_RDATA_O <= 32'h00000000;
                S_AXI_RRESP_O <= `SLC_RESP_SLVERR;
            end
        end else if (S_AXI_RVALID_O & S_AXI_RREADY_I) begin
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_ARREADY_O <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // cgs exit gating
    // ------------------------------------------------------------------
    reg  [0:0] state_r;                     // link layer state
    reg  [0:0] state_nxt;                   // its next value
    wire       bypass_on;                   // bypass in force
    wire       exit_ok;                     // cgs exit allowed
    wire       seen_now;                    // sysref sampled by now

    // bypass is ignored outside subclass 1
    assign bypass_on = cgs_bypass & (SUBCLASS_I == `SLC_SUBCLASS_1);
    // registered edge with one-shot cleared; a realign-cycle tick is stale
    assign seen_now  = SYSREF_SEEN_O & ~single_det;
    // sysref sampled and one-shot cleared, or bypass in force
    assign exit_ok   = bypass_on |
                       seen_now;

    // state transition: cgs exits only on a multiframe boundary
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_CGS: begin
                if (CGS_DONE_I & exit_ok & LMFC_TICK_O) begin
                    state_nxt = ST_ILAS;
                end
            end
            ST_ILAS: begin
                state_nxt = ST_ILAS;
            end
            default: begin
                state_nxt = ST_CGS;
            end
        endcase
        if (LINK_RESET_I) begin
            // link reset drops back to code group sync
            state_nxt = ST_CGS;
        end
    end

    // state, status flags and the exit pulse
    always @(posedge CLK_I) begin
        if (RST_I) begin
            state_r       <= ST_CGS;
            IN_CGS_O      <= 1'b1;
            ILAS_START_O  <= 1'b0;
            SYSREF_SEEN_O <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            IN_CGS_O     <= (state_nxt == ST_CGS);
            ILAS_START_O <= (state_r == ST_CGS) & (state_nxt == ST_ILAS);
            if (realign) begin
                // a new edge wins over a link reset in the same cycle
                SYSREF_SEEN_O <= 1'b1;
            end else if (LINK_RESET_I) begin
                // sampling must be re-armed by software after reset
                SYSREF_SEEN_O <= 1'b0;
            end
        end
    end

endmodule // slc_align_ctrl

//--- verif/slc_align_ctrl_assertions.sv
// concurrent checks on the ports of the sysref / lmfc alignment block
`timescale 1ns/1ps
module slc_align_ctrl_chk #(
    parameter CNT_W = 11                  // lmfc counter width
) (
    input wire             CLK_I,
    input wire             RST_I,
    input wire             S_AXI_AWVALID_I,
    input wire             S_AXI_AWREADY_O,
    input wire             S_AXI_WVALID_I,
    input wire             S_AXI_WREADY_O,
    input wire [1:0]       S_AXI_BRESP_O,
    input wire             S_AXI_BVALID_O,
    input wire             S_AXI_BREADY_I,
    input wire [31:0]      S_AXI_RDATA_O,
    input wire             S_AXI_RVALID_O,
    input wire             S_AXI_RREADY_I,
    input wire [1:0]       SUBCLASS_I,
    input wire [7:0]       CFG_F_I,
    input wire [5:0]       CFG_K_I,
    input wire             LINK_RESET_I,
    input wire             CGS_DONE_I,
    input wire [CNT_W-1:0] LMFC_CNT_O,
    input wire             LMFC_TICK_O,
    input wire             IN_CGS_O,
    input wire             ILAS_START_O,
    input wire             SYSREF_SEEN_O
);
    // highest count of one multiframe, f*k/4 - 1
    wire [13:0]      prod_w = CFG_F_I * CFG_K_I;
    wire [CNT_W-1:0] last_w = (prod_w[13:2] == 12'h000) ? {CNT_W{1'b0}}
                                                        : CNT_W'(prod_w[13:2] - 12'h001);

    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    cnt_range_a: assert property (LMFC_CNT_O <= last_w)
        else $error("lmfc count beyond multiframe end");
    wrap_tick_a: assert property (LMFC_CNT_O == last_w |=> LMFC_TICK_O || $rose(SYSREF_SEEN_O))
        else $error("no boundary tick after last count");
    tick_zero_a: assert property (LMFC_TICK_O && !$rose(SYSREF_SEEN_O)
        |-> LMFC_CNT_O == '0 && $past(LMFC_CNT_O) == last_w)
        else $error("tick without wrap to zero");
    exit_tick_a: assert property ($fell(IN_CGS_O) |-> $past(LMFC_TICK_O) && $past(CGS_DONE_I))
        else $error("cgs left between ticks");
    exit_sysref_a: assert property ($fell(IN_CGS_O) |-> SYSREF_SEEN_O ||
        $past(SUBCLASS_I) == 2'h1)
        else $error("cgs left without sampled sysref");
    ilas_pulse_a: assert property ($fell(IN_CGS_O) |-> ILAS_START_O ##1 !ILAS_START_O)
        else $error("ilas start not a single pulse at cgs exit");
    cgs_return_a: assert property (LINK_RESET_I |=> IN_CGS_O)
        else $error("link reset did not return to cgs");
    write_resp_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
        && S_AXI_WREADY_O |=> S_AXI_BVALID_O)
        else $error("no write response after address and data");
    bresp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
        |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped before ready");
    rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
        |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data dropped before ready");

    // main scenarios reached
    cover property ($fell(IN_CGS_O));
    cover property ($rose(SYSREF_SEEN_O));
    cover property ($fell(IN_CGS_O) && !SYSREF_SEEN_O);
endmodule // slc_align_ctrl_chk

bind slc_align_ctrl slc_align_ctrl_chk #(.CNT_W(CNT_W)) u_chk (
    .CLK_I, .RST_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O,
    .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_RDATA_O, .S_AXI_RVALID_O,
    .S_AXI_RREADY_I, .SUBCLASS_I, .CFG_F_I, .CFG_K_I, .LINK_RESET_I, .CGS_DONE_I,
    .LMFC_CNT_O, .LMFC_TICK_O, .IN_CGS_O, .ILAS_START_O, .SYSREF_SEEN_O);

//--- verif/slc_conv_model.sv
// converter-side model sharing the sysref reference with the block
`timescale 1ns/1ps
module slc_conv_model #(
    parameter PULSE_CYC = 4  // sysref high time in link clocks
) (
    input  wire clk_i,       // link clock
    input  wire fire_i,      // request one sysref pulse
    output reg  sysref_o     // shared sysref reference
);
    initial sysref_o = 1'b0;
    // edges land mid-cycle, so the block sees a truly asynchronous pin
    always @(posedge clk_i) begin
        if (fire_i) begin
            #13 sysref_o = 1'b1;
            repeat (PULSE_CYC) @(posedge clk_i);
            #13 sysref_o = 1'b0;
        end
    end
endmodule // slc_conv_model

//--- verif/slc_align_ctrl_tb_top.sv
// testbench for the sysref / lmfc alignment control block
`timescale 1ns/1ps
`include "slc_consts.vh"
module slc_align_ctrl_tb_top;
    localparam [11:0] A_CTRL = `SLC_ADDR_SYNC_SYSREF_CTRL;
    localparam [1:0]  OK     = `SLC_RESP_OKAY;
    localparam [1:0]  ERR    = `SLC_RESP_SLVERR;
    // f=4, k=8: multiframe of 8 link clocks
    logic        clk = 1'b0, rst = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, got;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0]  subclass = 2'h1, resp;
    logic        link_reset = 1'b0, cgs_done = 1'b0, fire = 1'b0;
    logic [10:0] c0;
    wire         awready, wready, bvalid, arready, rvalid, sysref;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [10:0]  lmfc_cnt;
    wire         in_cgs, ilas_start, sysref_seen, lmfc_tick;
    int          fails = 0, check_count = 0, n;

    initial forever #25 clk = ~clk;

    slc_conv_model u_conv (.clk_i(clk), .fire_i(fire), .sysref_o(sysref));

    slc_align_ctrl DUT (
        .CLK_I(clk), .RST_I(rst),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .SUBCLASS_I(subclass),
        .CFG_F_I(8'h04), .CFG_K_I(6'h08), .LINK_RESET_I(link_reset), .CGS_DONE_I(cgs_done),
        .SYSREF_I(sysref), .LMFC_CNT_O(lmfc_cnt), .LMFC_TICK_O(lmfc_tick),
        .IN_CGS_O(in_cgs), .ILAS_START_O(ilas_start), .SYSREF_SEEN_O(sysref_seen));

    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // one axi4-lite write, address and data offered together
    task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_done, w_done;
        @(posedge clk);
        awaddr <= a; wdata <= d; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        aw_done = 1'b0; w_done = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) begin aw_done = 1'b1; awvalid <= 1'b0; end
            if (wvalid && wready === 1'b1) begin w_done = 1'b1; wvalid <= 1'b0; end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    // one axi4-lite read, checked against data and response
    task rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        got = rdata; resp = rresp;
        rready <= 1'b0;
        chk(got, e);
        chk({30'h0, resp}, {30'h0, er});
    endtask

    task pulse;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask

    task wait_seen;
        for (n = 0; n < 100 && sysref_seen !== 1'b1; n++) @(posedge clk);
    endtask

    task wait_exit;
        for (n = 0; n < 100 && in_cgs !== 1'b0; n++) @(posedge clk);
    endtask

    task lreset;
        link_reset <= 1'b1;
        @(posedge clk);
        link_reset <= 1'b0;
    endtask

    task test_done;
        if (fails == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(A_CTRL, 32'h00000004, OK);
        axi_wr(A_CTRL, 32'hFFFFFFFF, 4'h1);
        rd_chk(A_CTRL, 32'h0000007C, OK);
        axi_wr(12'h058, 32'hFFFFFFFF, 4'hF);
        chk({30'h0, resp}, {30'h0, ERR});
        rd_chk(12'h058, 32'h0, ERR);
        // armed realign with preset 3, no sysref yet
        axi_wr(A_CTRL, 32'h00003004, 4'hF);
        cgs_done <= 1'b1;
        repeat (40) @(posedge clk);
        chk({31'h0, in_cgs}, 32'h1);
        pulse;
        wait_seen;
        chk({21'h0, lmfc_cnt}, 32'h3);
        rd_chk(A_CTRL, 32'h00003000, OK);
        wait_exit;
        chk({31'h0, ilas_start}, 32'h1);
        chk({21'h0, lmfc_cnt}, 32'h1);
        // boundary tick stands in the cycle after the last count
        while (lmfc_cnt !== 11'h7) @(posedge clk);
        @(posedge clk);
        chk({31'h0, lmfc_tick}, 32'h1);
        chk({21'h0, lmfc_cnt}, 32'h0);
        // disarmed: a further edge must not disturb the count
        c0 = lmfc_cnt;
        pulse;
        repeat (19) @(posedge clk);
        chk({21'h0, lmfc_cnt}, 32'((c0 + 20) % 8));
        // re-arm after link reset with an out-of-range preset
        lreset;
        axi_wr(A_CTRL, 32'h00020004, 4'hF);
        pulse;
        wait_seen;
        chk({21'h0, lmfc_cnt}, 32'h0);
        // bypass outside subclass 1 has no effect
        subclass <= 2'h0;
        lreset;
        axi_wr(A_CTRL, 32'h00100000, 4'hF);
        repeat (30) @(posedge clk);
        chk({31'h0, in_cgs}, 32'h1);
        subclass <= 2'h1;
        wait_exit;
        chk({31'h0, in_cgs}, 32'h0);
        chk({31'h0, sysref_seen}, 32'h0);
        rd_chk(A_CTRL, 32'h00100000, OK);
        test_done;
    end

    // watchdog: the whole run needs well under a thousand clocks
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        test_done;
    end
endmodule // slc_align_ctrl_tb_top
